// File: pkg/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// register byte offsets
`define SCP_CTRL_OFS 8'h00
`define SCP_STATUS_OFS 8'h04
`define SCP_CMD_OFS 8'h08
// control fields and reset value
`define SCP_CTRL_CMD_EN 0
`define SCP_CTRL_LASER_INH 1
`define SCP_CTRL_RST 32'h0000_0001
// command codes
`define SCP_CMD_NULL 8'h00
`define SCP_CMD_FOCUS1 8'h08
`define SCP_CMD_FOCUS2 8'hA2
`define SCP_CMD_LASER_ON 8'h0A
`define SCP_CMD_LASER_OFF 8'h8A
// pin vector positions
`define SCP_PIN_WIN 0
`define SCP_PIN_DIN 1
`define SCP_PIN_HCK 2
`define SCP_PIN_CSN 3
`define SCP_PIN_MSB 4
`define SCP_PIN_PORN 5
`define SCP_PIN_SUBCODE_SHIFT_CLOCK 6
`define SCP_PIN_FZDN 7
`define SCP_PIN_VCO 8
`define SCP_PIN_XTAL 9
`define SCP_PIN_EFM 10
`define SCP_PIN_DSYNC 11
`define SCP_PIN_W 12
`define SCP_PIN_INIT 12'h028
// timing
`define SCP_CLK_MHZ 250
`define SCP_FOC_LOWER_US 200
`define SCP_FRAME_DIV 2304
`define SCP_SYNC_WIN 16
// q subcode layout
`define SCP_Q_DATA_BITS 80
`define SCP_Q_ALL_BITS 96
`define SCP_CRC_POLY 16'h1021

`endif

// File: pkg/scp_pkg.sv
package scp_pkg;

  // focus sequence states
  typedef enum logic [1:0] {
    SCP_F_IDLE,
    SCP_F_LOWER,
    SCP_F_SWEEP,
    SCP_F_SERVO
  } scp_focus_t;

  // ahb-lite request signals from the master
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } scp_ahb_req_t;

  // status word as software sees it
  typedef struct packed {
    logic [25:0] zero;
    logic match;
    logic servo;
    logic sweep;
    logic lowering;
    logic ready;
    logic laser;
  } scp_status_t;

endpackage : scp_pkg

// File: logic/scp_pin_sync.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

// three-stage pin synchroniser; a change is taken once stages 2 and 3 agree
module scp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // raw pins and filtered levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1; // metastability catcher, read only by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree; // bits where the last two stages match

  assign agree = ~(s2 ^ s3);

  // shift chain and filtered output
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level_o <= INIT;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= (s2 & agree) | (level_o & ~agree);
    end
  end

endmodule : scp_pin_sync

// File: logic/scp_servo_port.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

// Operation
// - commands run on window falling edge
// - commands accepted only with select low
// - 08 starts focus variant one
// - A2 starts focus variant two
// - 0A turns laser on
// - 8A or reset turns laser off
// - 00 returns focus to idle
// - laser steered by serial command
// - q crc pass raises ready
// - q bits shift out on host clock
// - bit-order low selects lsb first
// - eight subcode clocks shift p to w
// - subcode frame sync output
// - subcode block sync output
// - 7.35 khz frame rate sync
// - monitor clock is vco halved
// - sync match latched one frame
// - phase detect high when vco lags
// - 4.2336 mhz clock from crystal
// - zero-detect fall ends sweep, servo on
// - zero-detect ignored while lowering
// - window rise after focus start reinitialises
module scp_servo_port #(
  parameter int LOWER_CYCLES = `SCP_FOC_LOWER_US * `SCP_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire scp_pkg::scp_ahb_req_t ahb_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // host pins
  input wire logic command_window_i,
  input wire logic command_serial_in_i,
  input wire logic host_shift_clock_i,
  input wire logic chip_select_n_i,
  input wire logic bit_order_msb_i,
  input wire logic power_on_reset_n_i,
  input wire logic subcode_shift_clock_i,
  output logic subcode_ready_o,
  output logic q_subcode_serial_out_o,
  output logic subcode_serial_out_o,
  output logic subcode_frame_sync_o,
  output logic subcode_block_sync_o,
  // demodulator side, same clock
  input wire logic [7:0] subcode_byte_i,
  input wire logic subcode_valid_i,
  input wire logic subcode_block_start_i,
  // analog side pins
  input wire logic focus_zero_detect_n_i,
  input wire logic vco_clock_i,
  input wire logic crystal_clock_i,
  input wire logic efm_data_i,
  input wire logic disc_frame_sync_i,
  output logic focus_sweep_o,
  output logic focus_lower_n_o,
  output logic focus_servo_on_o,
  output logic laser_drive_n_o,
  output logic frame_rate_sync_o,
  output logic half_vco_clock_o,
  output logic clock_4m2_o,
  output logic sync_match_flag_o,
  output logic phase_detect_out_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------- pin synchronisers ----------------
  logic [`SCP_PIN_W-1:0] pins; // raw pin vector
  logic [`SCP_PIN_W-1:0] lvl; // filtered levels
  logic [`SCP_PIN_W-1:0] lvl_q; // levels one cycle back
  logic [`SCP_PIN_W-1:0] rise; // rising edge pulses
  logic [`SCP_PIN_W-1:0] fall; // falling edge pulses

  assign pins = {disc_frame_sync_i, efm_data_i, crystal_clock_i, vco_clock_i,
                 focus_zero_detect_n_i, subcode_shift_clock_i, power_on_reset_n_i,
                 bit_order_msb_i, chip_select_n_i, host_shift_clock_i,
                 command_serial_in_i, command_window_i};

  scp_pin_sync #(.W(`SCP_PIN_W), .INIT(`SCP_PIN_INIT)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pins),
    .level_o(lvl)
  );

  // edge detection works on the filtered levels only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) lvl_q <= `SCP_PIN_INIT;
    else lvl_q <= lvl;
  end
  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;

  wire selected = ~lvl[`SCP_PIN_CSN]; // pull-down keeps it selected
  wire por_low = ~lvl[`SCP_PIN_PORN]; // pin reset of command state

  // ---------------- register file ----------------
  logic [31:0] ctrl; // software control word
  logic [7:0] last_cmd; // last executed command code
  scp_pkg::scp_focus_t fstate; // focus sequence state
  logic laser_on; // laser drive state
  logic q_ready; // q data waiting
  scp_pkg::scp_status_t status;

  wire cmd_en = ctrl[`SCP_CTRL_CMD_EN];
  wire addr_ok = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
  wire wr_addr = addr_ok & ahb_i.hwrite;
  wire rd_addr = addr_ok & ~ahb_i.hwrite;
  wire [7:0] ofs = ahb_i.haddr[7:0];
  logic wr_ctrl_q; // data phase of a control write pending

  assign status = '{zero: '0, match: sync_match_flag_o,
                    servo: fstate == scp_pkg::SCP_F_SERVO,
                    sweep: fstate == scp_pkg::SCP_F_SWEEP,
                    lowering: fstate == scp_pkg::SCP_F_LOWER,
                    ready: q_ready, laser: laser_on};

  // read mux; unmapped offsets read zero
  wire [31:0] rd_val = (ofs == `SCP_CTRL_OFS) ? ctrl :
                       (ofs == `SCP_STATUS_OFS) ? 32'(status) :
                       (ofs == `SCP_CMD_OFS) ? {24'h00_0000, last_cmd} : 32'h0000_0000;

  assign hreadyout_o = 1'b1; // zero wait states
  assign hresp_o = 1'b0; // always okay

  // bus slave: read data is captured in the address phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl <= `SCP_CTRL_RST;
      wr_ctrl_q <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      wr_ctrl_q <= wr_addr & (ofs == `SCP_CTRL_OFS);
      if (rd_addr) hrdata_o <= rd_val;
      if (wr_ctrl_q) ctrl <= hwdata_i & 32'h0000_0003;
    end
  end

  // ---------------- command shifter ----------------
  logic [7:0] cmd_sr; // incoming bits
  logic [2:0] bit_cnt; // bits of the current byte
  logic [7:0] cmd_byte; // last complete byte
  logic [7:0] prev_byte; // byte before it; no command decode reads it
  logic have_byte; // at least one full byte this window
  wire shift_en = lvl[`SCP_PIN_WIN] & rise[`SCP_PIN_HCK] & selected & cmd_en;
  wire [7:0] next_sr = {cmd_sr[6:0], lvl[`SCP_PIN_DIN]}; // msb arrives first
  wire exec = fall[`SCP_PIN_WIN] & have_byte & selected & cmd_en;

  // shift register restarts on every window rise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_sr <= 8'h00;
      bit_cnt <= 3'h0;
      cmd_byte <= 8'h00;
      prev_byte <= 8'h00;
      have_byte <= 1'b0;
    end else if (rise[`SCP_PIN_WIN]) begin
      bit_cnt <= 3'h0;
      have_byte <= 1'b0;
    end else if (shift_en) begin
      cmd_sr <= next_sr;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        cmd_byte <= next_sr;
        prev_byte <= cmd_byte;
        have_byte <= 1'b1;
      end
    end
  end

  p_exec_on_fall: assert property (exec |-> fall[`SCP_PIN_WIN] && selected)
    else $error("command ran without window fall");
  p_shift_selected: assert property (!selected && !rise[`SCP_PIN_WIN] |=> $stable(bit_cnt))
    else $error("bit taken while deselected");

  // ---------------- laser and focus ----------------
  logic fs_started; // focus start waits for window rise
  logic fs_var2; // variant two keeps sweep off while lowering
  logic [16:0] low_cnt; // lowering time counter
  scp_pkg::scp_focus_t next_fstate;
  wire is_fs1 = exec & (cmd_byte == `SCP_CMD_FOCUS1);
  wire is_fs2 = exec & (cmd_byte == `SCP_CMD_FOCUS2);
  wire is_null = exec & (cmd_byte == `SCP_CMD_NULL);
  wire fzd_fall = fall[`SCP_PIN_FZDN];

  // next focus state; pin reset and null win over progression
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      scp_pkg::SCP_F_LOWER: begin
        if (low_cnt == 17'(LOWER_CYCLES - 1)) next_fstate = scp_pkg::SCP_F_SWEEP;
      end
      scp_pkg::SCP_F_SWEEP: begin
        if (fzd_fall) next_fstate = scp_pkg::SCP_F_SERVO;
      end
      scp_pkg::SCP_F_IDLE: next_fstate = scp_pkg::SCP_F_IDLE;
      scp_pkg::SCP_F_SERVO: next_fstate = scp_pkg::SCP_F_SERVO;
      default: next_fstate = scp_pkg::SCP_F_IDLE;
    endcase
    if (is_fs1 | is_fs2) next_fstate = scp_pkg::SCP_F_LOWER;
    if (rise[`SCP_PIN_WIN] & fs_started) next_fstate = scp_pkg::SCP_F_IDLE;
    if (is_null | por_low) next_fstate = scp_pkg::SCP_F_IDLE;
  end

  // focus state and its registered pin outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fstate <= scp_pkg::SCP_F_IDLE;
      low_cnt <= 17'h0_0000;
      fs_started <= 1'b0;
      fs_var2 <= 1'b0;
      focus_lower_n_o <= 1'b1;
      focus_sweep_o <= 1'b0;
      focus_servo_on_o <= 1'b0;
    end else begin
      fstate <= next_fstate;
      low_cnt <= (next_fstate == scp_pkg::SCP_F_LOWER && fstate == next_fstate) ?
                 low_cnt + 17'h0_0001 : 17'h0_0000;
      if (is_fs1 | is_fs2) fs_var2 <= is_fs2;
      fs_started <= (is_fs1 | is_fs2) ? 1'b1 : (rise[`SCP_PIN_WIN] ? 1'b0 : fs_started);
      focus_lower_n_o <= next_fstate != scp_pkg::SCP_F_LOWER;
      // variant two leaves the sweep off while the lens is lowered
      focus_sweep_o <= (next_fstate == scp_pkg::SCP_F_SWEEP) |
                       ((next_fstate == scp_pkg::SCP_F_LOWER) & ~(is_fs2 | (fs_var2 & ~is_fs1)));
      focus_servo_on_o <= next_fstate == scp_pkg::SCP_F_SERVO;
    end
  end

  // laser drive is active low; inhibit bit forces it off
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      laser_on <= 1'b0;
      last_cmd <= 8'h00;
      laser_drive_n_o <= 1'b1;
    end else begin
      if (por_low) laser_on <= 1'b0;
      else if (exec && cmd_byte == `SCP_CMD_LASER_ON) laser_on <= 1'b1;
      else if (exec && cmd_byte == `SCP_CMD_LASER_OFF) laser_on <= 1'b0;
      if (exec) last_cmd <= cmd_byte;
      laser_drive_n_o <= ~(laser_on & ~ctrl[`SCP_CTRL_LASER_INH]);
    end
  end

  p_laser_on: assert property (exec && cmd_byte == `SCP_CMD_LASER_ON && !por_low
                               |=> laser_on ##1 laser_drive_n_o == ctrl[`SCP_CTRL_LASER_INH])
    else $error("laser on command not applied");
  p_laser_off: assert property ((exec && cmd_byte == `SCP_CMD_LASER_OFF) || por_low
                                |=> !laser_on ##1 laser_drive_n_o)
    else $error("laser not off");
  p_focus_start: assert property ((is_fs1 || is_fs2) && !por_low
                                  |=> fstate == scp_pkg::SCP_F_LOWER && !focus_lower_n_o)
    else $error("focus start did not lower lens");
  p_null_idle: assert property (is_null |=> fstate == scp_pkg::SCP_F_IDLE && !focus_sweep_o)
    else $error("null did not idle focus");
  p_zero_detect: assert property (fstate == scp_pkg::SCP_F_SWEEP && fzd_fall && !exec
                                  && !por_low && !rise[`SCP_PIN_WIN]
                                  |=> focus_servo_on_o && !focus_sweep_o)
    else $error("zero detect did not start servo");
  p_zd_ignored: assert property (!focus_lower_n_o && fzd_fall && !exec && !por_low
                                 && !rise[`SCP_PIN_WIN] |=> fstate != scp_pkg::SCP_F_SERVO)
    else $error("zero detect taken while lowering");
  p_reinit: assert property (fs_started && rise[`SCP_PIN_WIN] |=> fstate == scp_pkg::SCP_F_IDLE)
    else $error("focus not reinitialised");

  // ---------------- subcode capture and q crc ----------------
  logic [7:0] sc_sr; // p..w bits of the current frame
  logic [3:0] sc_left; // subcode clocks still expected
  logic [6:0] frm; // frame index within the block
  logic [6:0] q_cnt; // q bits gathered this block
  logic [79:0] q_acc; // q data being gathered
  logic [15:0] crc; // running crc over q data
  logic [15:0] crc_rx; // received crc bits
  logic [79:0] q_out; // checked q data for the host
  logic [6:0] q_ptr; // next bit the host reads
  wire q_bit = subcode_byte_i[6];
  wire q_take = subcode_valid_i & ~subcode_block_start_i & (frm >= 7'd1) & (q_cnt < 7'd96);
  wire crc_fb = q_bit ^ crc[15];
  wire [15:0] next_crc = {crc[14:0], 1'b0} ^ (crc_fb ? `SCP_CRC_POLY : 16'h0000);
  wire crc_ok = q_take & (q_cnt == 7'(`SCP_Q_ALL_BITS - 1)) &
                ({crc_rx[14:0], q_bit} == ~crc);
  wire subcode_shift_clock = rise[`SCP_PIN_SUBCODE_SHIFT_CLOCK];
  wire rd_clk = rise[`SCP_PIN_HCK] & ~lvl[`SCP_PIN_WIN] & selected;

  // frame load and p..w shift-out, p first
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sc_sr <= 8'h00;
      sc_left <= 4'h0;
      subcode_serial_out_o <= 1'b0;
      subcode_frame_sync_o <= 1'b0;
      subcode_block_sync_o <= 1'b0;
    end else begin
      if (subcode_valid_i) begin
        sc_sr <= subcode_byte_i;
        sc_left <= 4'h8;
        subcode_frame_sync_o <= 1'b1;
        subcode_block_sync_o <= subcode_block_start_i;
      end else if (subcode_shift_clock && sc_left != 4'h0) begin
        sc_sr <= {sc_sr[6:0], 1'b0};
        sc_left <= sc_left - 4'h1;
        subcode_frame_sync_o <= 1'b0;
        subcode_block_sync_o <= 1'b0;
      end
      subcode_serial_out_o <= sc_sr[7];
    end
  end

  p_pw_shift: assert property (subcode_shift_clock && !subcode_valid_i && sc_left != 4'h0
                               |=> ##1 subcode_serial_out_o == $past(sc_sr[6], 2))
    else $error("subcode bit order wrong");

  // q gathering; the sync frame and the one after it carry no q bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frm <= 7'h00;
      q_cnt <= 7'h00;
      q_acc <= 80'h0;
      crc <= 16'h0000;
      crc_rx <= 16'h0000;
    end else if (subcode_valid_i) begin
      frm <= subcode_block_start_i ? 7'h00 : ((frm == 7'h7F) ? frm : frm + 7'h01);
      if (subcode_block_start_i) begin
        q_cnt <= 7'h00;
        crc <= 16'h0000;
      end else if (q_take) begin
        q_cnt <= q_cnt + 7'h01;
        if (q_cnt < 7'(`SCP_Q_DATA_BITS)) begin
          q_acc <= {q_acc[78:0], q_bit};
          crc <= next_crc;
        end else begin
          crc_rx <= {crc_rx[14:0], q_bit};
        end
      end
    end
  end

  // host readout; a crc pass sets ready and wins over any clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_out <= 80'h0;
      q_ptr <= 7'h00;
      q_ready <= 1'b0;
    end else begin
      if (crc_ok) begin
        q_out <= q_acc;
        q_ptr <= 7'h00;
        q_ready <= 1'b1;
      end else begin
        if (rd_clk && q_ptr != 7'(`SCP_Q_DATA_BITS - 1)) q_ptr <= q_ptr + 7'h01;
        if (rd_clk || (subcode_valid_i && subcode_block_start_i)) q_ready <= 1'b0;
      end
    end
  end

  // bit select: within each byte order follows the order pin
  wire [2:0] q_k = lvl[`SCP_PIN_MSB] ? q_ptr[2:0] : ~q_ptr[2:0];
  wire [6:0] q_pos = 7'(`SCP_Q_DATA_BITS - 1) - {q_ptr[6:3], q_k};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) q_subcode_serial_out_o <= 1'b0;
    else q_subcode_serial_out_o <= q_out[q_pos];
  end
  assign subcode_ready_o = q_ready;

  p_crc_ready: assert property (crc_ok |=> q_ready && q_ptr == 7'h00)
    else $error("crc pass did not raise ready");
  p_ready_clear: assert property (q_ready && rd_clk && !crc_ok |=> !q_ready)
    else $error("ready not cleared by read");
  p_q_order: assert property (q_ready && !rd_clk && !crc_ok |=> ##1
                              q_subcode_serial_out_o == $past(q_out[q_pos]))
    else $error("q bit mismatch");

  // ---------------- clocks and monitors ----------------
  logic [11:0] fr_cnt; // crystal edges within one frame
  logic [1:0] x_div; // crystal divide by four
  logic match_pend; // match seen in the current frame
  wire x_tick = rise[`SCP_PIN_XTAL];
  wire fr_tick = x_tick & (fr_cnt == 12'(`SCP_FRAME_DIV - 1));

  // 7.35 khz is the crystal over 2304; 4.2336 mhz is it over four
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fr_cnt <= 12'h000;
      x_div <= 2'h0;
      frame_rate_sync_o <= 1'b0;
      clock_4m2_o <= 1'b0;
      half_vco_clock_o <= 1'b0;
      match_pend <= 1'b0;
      sync_match_flag_o <= 1'b0;
      phase_detect_out_o <= 1'b0;
    end else begin
      if (x_tick) begin
        fr_cnt <= fr_tick ? 12'h000 : fr_cnt + 12'h001;
        x_div <= x_div + 2'h1;
        clock_4m2_o <= x_div[0] ? ~clock_4m2_o : clock_4m2_o;
      end
      frame_rate_sync_o <= fr_cnt < 12'(`SCP_FRAME_DIV / 2);
      if (rise[`SCP_PIN_VCO]) half_vco_clock_o <= ~half_vco_clock_o;
      // flag shows the previous frame's match for exactly one frame
      if (fr_tick) begin
        sync_match_flag_o <= match_pend;
        match_pend <= 1'b0;
      end else if (rise[`SCP_PIN_DSYNC] && fr_cnt < 12'(`SCP_SYNC_WIN)) begin
        match_pend <= 1'b1;
      end
      // data edge before vco edge means the vco lags: drive up
      if (rise[`SCP_PIN_EFM] | fall[`SCP_PIN_EFM]) phase_detect_out_o <= 1'b1;
      else if (rise[`SCP_PIN_VCO]) phase_detect_out_o <= 1'b0;
    end
  end

  p_match_frame: assert property (!$stable(sync_match_flag_o) |-> $past(fr_tick))
    else $error("match flag moved off frame boundary");

endmodule : scp_servo_port

// File: verif/scp_host_model.sv
`timescale 1ns/1ps
// host side of the command port; n sets how slowly it moves
module scp_host_model (
  // clock
  input wire logic clk_i,
  // host pins
  output logic command_window_o,
  output logic command_serial_in_o,
  output logic host_shift_clock_o,
  output logic subcode_shift_clock_o
);
  initial begin
    command_window_o = 1'b0;
    command_serial_in_o = 1'b0;
    host_shift_clock_o = 1'b0;
    subcode_shift_clock_o = 1'b0;
  end
  // the pin filter needs each level to stand several cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // one byte msb first inside a window
  task automatic send(input logic [7:0] code, input int n);
    hold(1);
    command_window_o <= 1'b1;
    hold(n);
    for (int i = 7; i >= 0; i--) begin
      command_serial_in_o <= code[i];
      host_shift_clock_o <= 1'b0;
      hold(n);
      host_shift_clock_o <= 1'b1;
      hold(n);
    end
    command_window_o <= 1'b0;
    // released data line flips so a stale bit cannot pass
    command_serial_in_o <= ~code[0];
    hold(n);
  endtask : send
  // one subcode clock pulse
  task automatic sub_clock(input int n);
    subcode_shift_clock_o <= 1'b1;
    hold(n);
    subcode_shift_clock_o <= 1'b0;
    hold(n);
  endtask : sub_clock
endmodule : scp_host_model

// File: verif/test_scp_servo_port.sv
`timescale 1ns/1ps
`include "scp_defs.svh"
module test_scp_servo_port;
  // lowering kept short so runs stay brief
  localparam int LOWER = 60;
  logic clk_i, sys_rst_i, hready, hresp;
  scp_pkg::scp_ahb_req_t req, ahb;
  logic [31:0] hwdata, hrdata, rd;
  logic win, din, hck, subcode_shift_clock, porn, fzdn, vco, xtal, csn, msb, sq, half_vco_clock, c4m, frame_rate_sync;
  logic [3:0] acnt = 4'h0; // slow analog clock source
  assign xtal = acnt[2];
  assign vco = acnt[3];
  logic [7:0] sc_byte;
  logic sc_valid, sc_blk, rdy, pw, subcode_frame_sync, subcode_block_sync;
  logic sweep, lower_n, servo, laser_n;
  int fails, num_checks, cyc;
  // the slave's hreadyout is the bus hready
  always_comb begin
    ahb = req;
    ahb.hready = hready;
  end
  scp_host_model u_host (.clk_i(clk_i), .command_window_o(win),
    .command_serial_in_o(din), .host_shift_clock_o(hck), .subcode_shift_clock_o(subcode_shift_clock));
  scp_servo_port #(.LOWER_CYCLES(LOWER)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ahb_i(ahb), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .command_window_i(win), .command_serial_in_i(din),
    .host_shift_clock_i(hck), .chip_select_n_i(csn), .bit_order_msb_i(msb),
    .power_on_reset_n_i(porn), .subcode_shift_clock_i(subcode_shift_clock), .subcode_ready_o(rdy),
    .q_subcode_serial_out_o(sq), .subcode_serial_out_o(pw), .subcode_frame_sync_o(subcode_frame_sync),
    .subcode_block_sync_o(subcode_block_sync), .subcode_byte_i(sc_byte), .subcode_valid_i(sc_valid),
    .subcode_block_start_i(sc_blk), .focus_zero_detect_n_i(fzdn), .vco_clock_i(vco),
    .crystal_clock_i(xtal), .efm_data_i(1'b0), .disc_frame_sync_i(1'b0),
    .focus_sweep_o(sweep), .focus_lower_n_o(lower_n), .focus_servo_on_o(servo),
    .laser_drive_n_o(laser_n), .frame_rate_sync_o(frame_rate_sync), .half_vco_clock_o(half_vco_clock),
    .clock_4m2_o(c4m), .sync_match_flag_o(), .phase_detect_out_o());
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // slow analog clocks and a hang limit
  always @(posedge clk_i) begin
    acnt <= acnt + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // single word transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    req <= '{1'b1, 2'h2, a, wr, 3'h2, 1'b1};
    do @(posedge clk_i); while (hready !== 1'b1);
    req.htrans <= 2'h0;
    req.hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // command then settle; outputs follow the window fall within a few cycles
  task automatic cmd(input logic [7:0] c);
    u_host.send(c, 10);
    u_host.hold(6);
  endtask : cmd
  task automatic t_reset;
    chk("laser_n", 1, laser_n);
    chk("lower_n", 1, lower_n);
    chk("sweep", 0, sweep);
    chk("fsx", 1, frame_rate_sync);
    chk("q_subcode_serial_out", 0, sq);
    bus(0, 32'h0, 0);
    chk("ctrl", `SCP_CTRL_RST, rd);
    bus(0, 32'h0C, 0);
    chk("unmapped", 0, rd);
  endtask : t_reset
  task automatic t_laser;
    cmd(`SCP_CMD_LASER_ON);
    chk("laser on", 0, laser_n);
    bus(0, 32'h08, 0);
    chk("last code", 32'h0A, rd);
    cmd(`SCP_CMD_LASER_OFF);
    chk("laser off", 1, laser_n);
    // commands disabled: the code must have no effect
    bus(1, 32'h0, 0);
    cmd(`SCP_CMD_LASER_ON);
    chk("disabled", 1, laser_n);
    bus(1, 32'h0, 1);
    cmd(`SCP_CMD_LASER_ON);
    porn <= 1'b0;
    u_host.hold(12);
    chk("porn laser", 1, laser_n);
    porn <= 1'b1;
    csn <= 1'b1;
    u_host.hold(8);
    cmd(`SCP_CMD_LASER_ON);
    chk("deselected", 1, laser_n);
    csn <= 1'b0;
  endtask : t_laser
  // vco rises every 16 cycles, crystal every 8: both outputs toggle every 16
  task automatic t_clocks;
    int np, nc;
    logic lp, lc;
    np = 0;
    nc = 0;
    lp = half_vco_clock;
    lc = c4m;
    repeat (128) begin
      @(posedge clk_i);
      if (half_vco_clock !== lp) np++;
      if (c4m !== lc) nc++;
      lp = half_vco_clock;
      lc = c4m;
    end
    chk("pck toggles", 8, np);
    chk("4m2 toggles", 8, nc);
  endtask : t_clocks
  task automatic t_focus1;
    cmd(`SCP_CMD_FOCUS1);
    chk("f1 lower", 0, lower_n);
    chk("f1 sweep", 1, sweep);
    u_host.hold(LOWER + 10);
    chk("f1 raise", 1, lower_n);
    fzdn <= 1'b0;
    u_host.hold(12);
    chk("f1 sweep end", 0, sweep);
    chk("f1 servo", 1, servo);
    fzdn <= 1'b1;
    cmd(`SCP_CMD_NULL);
    chk("null servo", 0, servo);
    chk("null lower", 1, lower_n);
  endtask : t_focus1
  task automatic t_focus2;
    cmd(`SCP_CMD_FOCUS2);
    chk("f2 lower", 0, lower_n);
    chk("f2 sweep", 0, sweep);
    fzdn <= 1'b0;
    u_host.hold(12);
    fzdn <= 1'b1;
    u_host.hold(LOWER);
    chk("f2 ignored", 0, servo);
    chk("f2 sweep", 1, sweep);
    cmd(`SCP_CMD_NULL);
    chk("f2 idle", 0, sweep);
  endtask : t_focus2
  task automatic t_subcode;
    sc_byte <= 8'hA5;
    sc_blk <= 1'b1;
    sc_valid <= 1'b1;
    @(posedge clk_i);
    sc_valid <= 1'b0;
    u_host.hold(4);
    chk("frame sync", 1, subcode_frame_sync);
    chk("block sync", 1, subcode_block_sync);
    for (int i = 7; i >= 0; i--) begin
      chk("pw bit", 32'(sc_byte[i]), pw);
      u_host.sub_clock(10);
    end
    chk("frame sync end", 0, subcode_frame_sync);
  endtask : t_subcode
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    {fails, num_checks, cyc} = '0;
    {sys_rst_i, porn, fzdn, csn, msb} = 5'h15;
    {req, hwdata, sc_byte, sc_valid, sc_blk} = '0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    porn <= 1'b1;
    repeat (8) @(posedge clk_i);
    t_reset();
    t_laser();
    t_focus1();
    t_focus2();
    t_subcode();
    t_clocks();
    finish_test();
  end
endmodule : test_scp_servo_port
